// >>> rtl/eepcw_regs.svh
`ifndef EEPCW_REGS_SVH
`define EEPCW_REGS_SVH
// opcodes
`define EEPCW_OP_WLSET 8'h06
`define EEPCW_OP_WLCLR 8'h04
`define EEPCW_OP_SRD 8'h05
`define EEPCW_OP_SWR 8'h01
`define EEPCW_OP_MRD 8'h03
`define EEPCW_OP_MWR 8'h02
// status field positions
`define EEPCW_SR_WIP 0
`define EEPCW_SR_WEL 1
`define EEPCW_SR_BGLO 2
`define EEPCW_SR_BGHI 3
`define EEPCW_SR_LOCKN 4
`define EEPCW_SR_IDSEL 6
`define EEPCW_SR_WMASK 8'h5C
// reset values of the volatile and non-volatile control bits
`define EEPCW_RST_BG 2'h0
`define EEPCW_RST_LOCKN 1'h1
`define EEPCW_RST_IDSEL 1'h1
// timing
`define EEPCW_TWC_US 4000
`define EEPCW_CLK_MHZ 100
`define EEPCW_TWC_CYC (`EEPCW_TWC_US * `EEPCW_CLK_MHZ)
`define EEPCW_SCK_HALF 4'h6
`endif

// >>> rtl/eepcw_pkg.sv
package eepcw_pkg;
  typedef enum logic [2:0] {
    EEPCW_DEV_OP, EEPCW_DEV_ADDR, EEPCW_DEV_WDATA, EEPCW_DEV_RDATA,
    EEPCW_DEV_SRD, EEPCW_DEV_SWR, EEPCW_DEV_SKIP
  } eepcw_dev_state_type;
  typedef enum logic [1:0] {
    EEPCW_HST_IDLE, EEPCW_HST_SHIFT, EEPCW_HST_GAP
  } eepcw_hst_state_type;
endpackage

// >>> rtl/eepcw_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface eepcw_link_if;
  logic chip_select_n;
  logic sck;
  logic sdi;
  logic sdo;
  logic sdo_oe;
  logic write_guard_n;
  modport host (output chip_select_n, output sck, output sdi, output write_guard_n,
    input sdo, input sdo_oe);
  modport device (input chip_select_n, input sck, input sdi, input write_guard_n,
    output sdo, output sdo_oe);
endinterface
`default_nettype wire

// >>> rtl/eepcw_device.sv
// Behaviour
// - only spi modes 0 and 3
// - capture 8-bit opcode, ignore unknown ones
// - 06 sets latch, 04 clears latch
// - 05 reads status, 01 writes status
// - 03 reads memory, 02 writes memory
// - write_in_progress high during internal write
// - set/clear commands drive write_enable_latch
// - guard bits protect quarter, half, all
// - id_page_select routes access, returns to 1
// - id_page_lock_n 0 locks id page forever
// - clearing select and lock together ignored
// - writes need guard pin high and latch
// - latch set on chip select rising edge
// - write frame opcode, address, data; bit3=a8
// - write starts on cs rise; only status read
// - 16-byte page load wraps within page
// - write completion clears write_enable_latch
// - id page uses address bits 3..0
// - id write refused: full guard, lock, guarded
// - status write changes bits 2,3,4,6 only
// - guard low after first data byte cancels write
// - sample rising edge, drive falling edge
// - reads stream with address wrap
`timescale 1ns/1ps
`default_nettype none
`include "eepcw_regs.svh"
module eepcw_device
  import eepcw_pkg::*;
#(
  parameter int ADDR_W = 9,
  parameter int TWC_CYC = `EEPCW_TWC_CYC
) (
  // system
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // link
  eepcw_link_if.device link,
  // user side
  output logic o_busy,
  output logic [7:0] o_status
);
  localparam int DEPTH = 1 << ADDR_W;
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cs_s_r, sck_s_r, sdi_s_r, wg_s_r;
  logic cs_d_r, sck_d_r;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cs_s_r <= 2'h3;
      sck_s_r <= 2'h0;
      sdi_s_r <= 2'h0;
      wg_s_r <= 2'h3;
      cs_d_r <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      cs_s_r <= {cs_s_r[0], link.chip_select_n};
      sck_s_r <= {sck_s_r[0], link.sck};
      sdi_s_r <= {sdi_s_r[0], link.sdi};
      wg_s_r <= {wg_s_r[0], link.write_guard_n};
      cs_d_r <= cs_s_r[1];
      sck_d_r <= sck_s_r[1];
    end
  end
  wire cs_n = cs_s_r[1];
  wire cs_rise = cs_n & ~cs_d_r;
  // mode 0 and 3 both sample on rising and shift on falling sck
  wire sck_rise = ~cs_n & sck_s_r[1] & ~sck_d_r;
  wire sck_fall = ~cs_n & ~sck_s_r[1] & sck_d_r;
  wire guard_n = wg_s_r[1];
  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0] mem_r [DEPTH];
  logic [7:0] idp_r [16];
  logic [7:0] pbuf_r [16];
  logic [15:0] pval_r;
  // ----------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------
  eepcw_dev_state_type st_r, st_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] op_r, op_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [7:0] out_r, out_nxt;
  logic sdo_r, sdo_nxt, oe_r, oe_nxt;
  logic wel_r, wel_nxt, wip_r, wip_nxt;
  logic [1:0] bg_r, bg_nxt;
  logic lockn_r, lockn_nxt, idsel_r, idsel_nxt;
  logic [1:0] bg_new_r, bg_new_nxt;
  logic lockn_new_r, lockn_new_nxt, idsel_new_r, idsel_new_nxt;
  logic pend_mem_r, pend_mem_nxt, pend_sr_r, pend_sr_nxt, wel_arm_r, wel_arm_nxt;
  logic tgt_id_r, tgt_id_nxt, cancel_r, cancel_nxt, acc_r, acc_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic pwr, pclr;
  logic [3:0] pidx;
  logic [7:0] pdat;
  wire [7:0] status = {1'b1, idsel_r, 1'b1, lockn_r, bg_r, wel_r, wip_r};

  // an address is guarded if it falls in the guarded fraction
  function automatic logic guarded(input logic [1:0] bg, input logic [ADDR_W-1:0] a);
    case (bg)
      2'b00: guarded = 1'b0;
      2'b01: guarded = (a[ADDR_W-1:ADDR_W-2] == 2'b11);
      2'b10: guarded = a[ADDR_W-1];
      default: guarded = 1'b1;
    endcase
  endfunction

  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    out_nxt = out_r;
    sdo_nxt = sdo_r;
    oe_nxt = oe_r;
    wel_nxt = wel_r;
    wip_nxt = wip_r;
    bg_nxt = bg_r;
    lockn_nxt = lockn_r;
    idsel_nxt = idsel_r;
    bg_new_nxt = bg_new_r;
    lockn_new_nxt = lockn_new_r;
    idsel_new_nxt = idsel_new_r;
    pend_mem_nxt = pend_mem_r;
    pend_sr_nxt = pend_sr_r;
    wel_arm_nxt = wel_arm_r;
    tgt_id_nxt = tgt_id_r;
    cancel_nxt = cancel_r;
    acc_nxt = acc_r;
    cnt_nxt = cnt_r;
    pwr = 1'b0;
    pclr = 1'b0;
    pidx = addr_r[3:0];
    pdat = {sh_r[6:0], sdi_s_r[1]};
    if (wip_r) begin
      if (cnt_r == 32'h0000_0000) begin
        wip_nxt = 1'b0;
        wel_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - 32'h0000_0001;
      end
    end
    if (~cs_n && ~guard_n && (pend_mem_r || pend_sr_r)) begin
      cancel_nxt = 1'b1;
    end
    if (cs_rise) begin
      st_nxt = EEPCW_DEV_OP;
      bit_nxt = 3'h0;
      oe_nxt = 1'b0;
      if (wel_arm_r) begin
        wel_nxt = 1'b1;
      end
      if (acc_r && !wip_r) begin
        idsel_nxt = 1'b1;
      end
      // start self-timed cycle on cs rise
      if ((pend_mem_r || pend_sr_r) && !cancel_r && guard_n && wel_r && !wip_r) begin
        wip_nxt = 1'b1;
        cnt_nxt = TWC_CYC[31:0];
        if (pend_sr_r) begin
          bg_nxt = bg_new_r;
          lockn_nxt = lockn_new_r;
          idsel_nxt = idsel_new_r;
        end
        if (pend_mem_r) begin
          idsel_nxt = 1'b1;
        end
      end
      pend_mem_nxt = 1'b0;
      pend_sr_nxt = 1'b0;
      wel_arm_nxt = 1'b0;
      cancel_nxt = 1'b0;
      acc_nxt = 1'b0;
    end else if (sck_fall && oe_r) begin
      sdo_nxt = out_r[7];
      out_nxt = {out_r[6:0], 1'b0};
    end else if (sck_rise) begin
      sh_nxt = pdat;
      bit_nxt = bit_r + 3'h1;
      wel_arm_nxt = 1'b0;
      if (bit_r == 3'h7) begin
        case (st_r)
          EEPCW_DEV_OP: begin
            op_nxt = pdat;
            st_nxt = EEPCW_DEV_SKIP;
            if (pdat == `EEPCW_OP_SRD) begin
              st_nxt = EEPCW_DEV_SRD;
              out_nxt = status;
              oe_nxt = 1'b1;
            end else if (!wip_r) begin
              case ({pdat[7:4], 1'b0, pdat[2:0]})
                `EEPCW_OP_WLSET: if (pdat[3] == 1'b0) wel_arm_nxt = 1'b1;
                `EEPCW_OP_WLCLR: if (pdat[3] == 1'b0) wel_nxt = 1'b0;
                `EEPCW_OP_SWR: if (pdat[3] == 1'b0) st_nxt = EEPCW_DEV_SWR;
                `EEPCW_OP_MRD: st_nxt = EEPCW_DEV_ADDR;
                `EEPCW_OP_MWR: st_nxt = EEPCW_DEV_ADDR;
                default: st_nxt = EEPCW_DEV_SKIP;
              endcase
            end
          end
          EEPCW_DEV_ADDR: begin
            addr_nxt = {op_r[3], pdat};
            tgt_id_nxt = ~idsel_r;
            acc_nxt = 1'b1;
            if ({op_r[7:4], 1'b0, op_r[2:0]} == `EEPCW_OP_MRD) begin
              st_nxt = EEPCW_DEV_RDATA;
              oe_nxt = 1'b1;
              out_nxt = idsel_r ? mem_r[{op_r[3], pdat}] : idp_r[pdat[3:0]];
            end else begin
              st_nxt = EEPCW_DEV_WDATA;
              pclr = 1'b1;
            end
          end
          EEPCW_DEV_WDATA: begin
            pwr = 1'b1;
            addr_nxt = {addr_r[ADDR_W-1:4], addr_r[3:0] + 4'h1};
            if (guarded(bg_r, addr_r) || (tgt_id_r && (!lockn_r || bg_r == 2'b11))) begin
              cancel_nxt = 1'b1;
            end
            pend_mem_nxt = wel_r & guard_n;
          end
          EEPCW_DEV_RDATA: begin
            addr_nxt = tgt_id_r ? {addr_r[ADDR_W-1:4], addr_r[3:0] + 4'h1} :
              addr_r + 1'b1;
            out_nxt = tgt_id_r ? idp_r[addr_r[3:0] + 4'h1] : mem_r[addr_r + 1'b1];
          end
          EEPCW_DEV_SRD: out_nxt = status;
          EEPCW_DEV_SWR: begin
            st_nxt = EEPCW_DEV_SKIP;
            bg_new_nxt = pdat[`EEPCW_SR_BGHI:`EEPCW_SR_BGLO];
            // clearing both select and lock is ignored
            if (!pdat[`EEPCW_SR_IDSEL] && !pdat[`EEPCW_SR_LOCKN]) begin
              lockn_new_nxt = lockn_r;
              idsel_new_nxt = idsel_r;
            end else begin
              lockn_new_nxt = lockn_r & pdat[`EEPCW_SR_LOCKN];
              idsel_new_nxt = pdat[`EEPCW_SR_IDSEL];
            end
            pend_sr_nxt = wel_r & guard_n;
          end
          default: st_nxt = EEPCW_DEV_SKIP;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= EEPCW_DEV_OP;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      op_r <= 8'h00;
      addr_r <= '0;
      out_r <= 8'h00;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
      wel_r <= 1'b0;
      wip_r <= 1'b0;
      bg_r <= `EEPCW_RST_BG;
      lockn_r <= `EEPCW_RST_LOCKN;
      idsel_r <= `EEPCW_RST_IDSEL;
      bg_new_r <= `EEPCW_RST_BG;
      lockn_new_r <= `EEPCW_RST_LOCKN;
      idsel_new_r <= `EEPCW_RST_IDSEL;
      pend_mem_r <= 1'b0;
      pend_sr_r <= 1'b0;
      wel_arm_r <= 1'b0;
      tgt_id_r <= 1'b0;
      cancel_r <= 1'b0;
      acc_r <= 1'b0;
      cnt_r <= 32'h0000_0000;
      pval_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      out_r <= out_nxt;
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
      wel_r <= wel_nxt;
      wip_r <= wip_nxt;
      bg_r <= bg_nxt;
      lockn_r <= lockn_nxt;
      idsel_r <= idsel_nxt;
      bg_new_r <= bg_new_nxt;
      lockn_new_r <= lockn_new_nxt;
      idsel_new_r <= idsel_new_nxt;
      pend_mem_r <= pend_mem_nxt;
      pend_sr_r <= pend_sr_nxt;
      wel_arm_r <= wel_arm_nxt;
      tgt_id_r <= tgt_id_nxt;
      cancel_r <= cancel_nxt;
      acc_r <= acc_nxt;
      cnt_r <= cnt_nxt;
      if (pclr) pval_r <= 16'h0000;
      else if (pwr) pval_r[pidx] <= 1'b1;
    end
  end

  // page buffer and array commit (no reset on storage)
  always_ff @(posedge i_clk_sys) begin
    if (pwr) pbuf_r[pidx] <= pdat;
    if (cs_rise && pend_mem_r && !cancel_r && guard_n && wel_r && !wip_r) begin
      for (int i = 0; i < 16; i++) begin
        if (pval_r[i] && tgt_id_r) idp_r[i] <= pbuf_r[i];
        if (pval_r[i] && !tgt_id_r) mem_r[{addr_r[ADDR_W-1:4], 4'(i)}] <= pbuf_r[i];
      end
    end
  end

  assign link.sdo = sdo_r;
  assign link.sdo_oe = oe_r;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
      // same value the status register holds out of reset
      o_status <= {1'b1, `EEPCW_RST_IDSEL, 1'b1, `EEPCW_RST_LOCKN, `EEPCW_RST_BG, 2'h0};
    end else begin
      o_busy <= wip_r;
      o_status <= status;
    end
  end
endmodule // eepcw_device
`default_nettype wire

// >>> rtl/eepcw_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "eepcw_regs.svh"
module eepcw_host
  import eepcw_pkg::*;
#(
  parameter int MAXB = 19
) (
  // system
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // link
  eepcw_link_if.host link,
  // user command: frame of i_nbytes bytes, first byte is opcode
  input wire logic i_start,
  input wire logic [4:0] i_nbytes,
  input wire logic [7:0] i_tx [MAXB],
  input wire logic i_guard_n,
  output logic o_busy,
  output logic o_rx_valid,
  output logic [7:0] o_rx
);
  // ----------------------------------------------------------------
  // frame engine, mode 0, sck derived by divider
  // ----------------------------------------------------------------
  logic [1:0] sdo_s_r;
  eepcw_hst_state_type st_r, st_nxt;
  logic [3:0] div_r, div_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [4:0] byt_r, byt_nxt;
  logic [4:0] n_r, n_nxt;
  logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt, rxo_r, rxo_nxt;
  logic cs_r, cs_nxt, sck_r, sck_nxt, sdi_r, sdi_nxt, busy_r, busy_nxt, v_r, v_nxt;
  always_comb begin
    st_nxt = st_r;
    div_nxt = div_r;
    bit_nxt = bit_r;
    byt_nxt = byt_r;
    n_nxt = n_r;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    rxo_nxt = rxo_r;
    cs_nxt = cs_r;
    sck_nxt = sck_r;
    sdi_nxt = sdi_r;
    busy_nxt = busy_r;
    v_nxt = 1'b0;
    case (st_r)
      EEPCW_HST_IDLE: if (i_start && i_nbytes != 5'h00) begin
        st_nxt = EEPCW_HST_SHIFT;
        n_nxt = i_nbytes;
        byt_nxt = 5'h00;
        bit_nxt = 3'h0;
        tx_nxt = i_tx[0];
        sdi_nxt = i_tx[0][7];
        cs_nxt = 1'b0;
        busy_nxt = 1'b1;
        div_nxt = `EEPCW_SCK_HALF;
      end
      EEPCW_HST_SHIFT: begin
        if (div_r != 4'h0) begin
          div_nxt = div_r - 4'h1;
        end else begin
          div_nxt = `EEPCW_SCK_HALF;
          sck_nxt = ~sck_r;
          if (!sck_r) begin
            rx_nxt = {rx_r[6:0], sdo_s_r[1]};
          end else begin
            bit_nxt = bit_r + 3'h1;
            tx_nxt = {tx_r[6:0], 1'b0};
            sdi_nxt = tx_r[6];
            if (bit_r == 3'h7) begin
              rxo_nxt = rx_r;
              v_nxt = 1'b1;
              byt_nxt = byt_r + 5'h01;
              if (byt_r + 5'h01 == n_r) begin
                st_nxt = EEPCW_HST_GAP;
              end else begin
                tx_nxt = i_tx[byt_r + 5'h01];
                sdi_nxt = i_tx[byt_r + 5'h01][7];
              end
            end
          end
        end
      end
      EEPCW_HST_GAP: begin
        // chip select rises right after the last byte
        cs_nxt = 1'b1;
        if (div_r != 4'h0) div_nxt = div_r - 4'h1;
        else if (cs_r) begin
          st_nxt = EEPCW_HST_IDLE;
          busy_nxt = 1'b0;
        end
      end
      default: st_nxt = EEPCW_HST_IDLE;
    endcase
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      sdo_s_r <= 2'h0;
      st_r <= EEPCW_HST_IDLE;
      div_r <= 4'h0;
      bit_r <= 3'h0;
      byt_r <= 5'h00;
      n_r <= 5'h00;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      rxo_r <= 8'h00;
      cs_r <= 1'b1;
      sck_r <= 1'b0;
      sdi_r <= 1'b0;
      busy_r <= 1'b0;
      v_r <= 1'b0;
    end else begin
      sdo_s_r <= {sdo_s_r[0], link.sdo & link.sdo_oe};
      st_r <= st_nxt;
      div_r <= div_nxt;
      bit_r <= bit_nxt;
      byt_r <= byt_nxt;
      n_r <= n_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      rxo_r <= rxo_nxt;
      cs_r <= cs_nxt;
      sck_r <= sck_nxt;
      sdi_r <= sdi_nxt;
      busy_r <= busy_nxt;
      v_r <= v_nxt;
    end
  end
  logic wg_r;
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) wg_r <= 1'b1;
    else wg_r <= i_guard_n;
  end
  assign link.chip_select_n = cs_r;
  assign link.sck = sck_r;
  assign link.sdi = sdi_r;
  assign link.write_guard_n = wg_r;
  assign o_busy = busy_r;
  assign o_rx_valid = v_r;
  assign o_rx = rxo_r;
endmodule // eepcw_host
`default_nettype wire

// >>> tb/eepcw_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module eepcw_assertions #(
  parameter int TWC_CYC = 400000
) (
  // system
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // link
  input wire logic chip_select_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic write_guard_n,
  // device user side
  input wire logic o_busy,
  input wire logic [7:0] o_status
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------
  // busy length counter
  // ----------------------------------------
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;
  always_comb begin
    busy_cnt_nxt = o_busy ? busy_cnt_r + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_cnt_r <= 32'h0000_0000;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_sck_idle;
    chip_select_n |-> !sck;
  endproperty
  property p_oe_off;
    chip_select_n [*8] |-> !sdo_oe;
  endproperty
  property p_sdo_edge;
    sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !sck;
  endproperty
  property p_sdi_edge;
    !chip_select_n && $changed(sdi) |-> !sck;
  endproperty
  property p_fixed;
    o_status[7] && o_status[5];
  endproperty
  property p_wip;
    $rose(o_busy) |-> ##[0:2] o_status[0];
  endproperty
  property p_commit;
    $rose(o_busy) |-> chip_select_n && write_guard_n && $past(o_status[1]);
  endproperty
  property p_busy_min;
    $fell(o_busy) |-> busy_cnt_r >= 32'(TWC_CYC);
  endproperty
  property p_busy_max;
    busy_cnt_r <= 32'(TWC_CYC + 64);
  endproperty
  property p_wel_done;
    $fell(o_busy) |-> ##[0:2] !o_status[1];
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("sck not idle low between frames");
  a_oe_off: assert property (p_oe_off)
    else $error("sdo driven while deselected");
  a_sdo_edge: assert property (p_sdo_edge)
    else $error("sdo changed while sck high");
  a_sdi_edge: assert property (p_sdi_edge)
    else $error("sdi changed while sck high");
  a_fixed: assert property (p_fixed)
    else $error("fixed status bits not one");
  a_wip: assert property (p_wip)
    else $error("write in progress bit not set");
  a_commit: assert property (p_commit)
    else $error("write started without latch or guard");
  a_busy_min: assert property (p_busy_min)
    else $error("write cycle too short");
  a_busy_max: assert property (p_busy_max)
    else $error("write cycle too long");
  a_wel_done: assert property (p_wel_done)
    else $error("latch not cleared after write");
  c_write: cover property ($rose(o_busy));
  c_done: cover property ($fell(o_busy) ##1 !o_status[1]);
  c_read: cover property (sdo_oe && !chip_select_n);
endmodule // eepcw_assertions
`default_nettype wire

// >>> tb/tb_spi_eeprom_command_write_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, e, g); \
  end \
end
module tb_spi_eeprom_command_write_control;
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic start = 1'b0;
  logic [4:0] nbytes = 5'h01;
  logic [7:0] tx [19];
  logic guard_n = 1'b1;
  logic hbusy;
  logic rxv;
  logic [7:0] rxb;
  logic dbusy;
  logic [7:0] dstat;
  logic [7:0] rx [$];
  logic seen;
  int n_mismatch = 0;
  int checks = 0;
  eepcw_link_if link ();
  eepcw_host eepcw_host_i (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .link(link),
    .i_start(start), .i_nbytes(nbytes), .i_tx(tx), .i_guard_n(guard_n),
    .o_busy(hbusy), .o_rx_valid(rxv), .o_rx(rxb));
  eepcw_device #(.TWC_CYC(1000)) eepcw_device_i (.i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst), .link(link), .o_busy(dbusy), .o_status(dstat));
  eepcw_assertions #(.TWC_CYC(1000)) eepcw_assertions_i (.i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst), .chip_select_n(link.chip_select_n), .sck(link.sck),
    .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe),
    .write_guard_n(link.write_guard_n), .o_busy(dbusy), .o_status(dstat));
  always #5 i_clk_sys = ~i_clk_sys;
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic stop_test;
    if (n_mismatch == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic hang(input string nm);
    n_mismatch++;
    $display("Error %s wait expected done seen timeout", nm);
    stop_test();
  endtask
  task automatic send(input int n, input logic [7:0] b0, b1 = 8'h00, b2 = 8'h00,
      b3 = 8'h00, b4 = 8'h00);
    int k;
    @(negedge i_clk_sys);
    tx[0] = b0;
    tx[1] = b1;
    tx[2] = b2;
    tx[3] = b3;
    tx[4] = b4;
    nbytes = 5'(n);
    start = 1'b1;
    @(negedge i_clk_sys);
    start = 1'b0;
    rx.delete();
    for (k = 0; k < 6000 && hbusy !== 1'b0; k++) begin
      @(posedge i_clk_sys);
      #1;
      if (rxv === 1'b1) begin
        rx.push_back(rxb);
      end
    end
    if (hbusy !== 1'b0) begin
      hang("host");
    end
  endtask
  // records whether a write cycle started, then waits for its end
  task automatic settle;
    int k;
    repeat (10) @(posedge i_clk_sys);
    seen = dbusy;
    for (k = 0; k < 3000 && dbusy !== 1'b0; k++) begin
      @(posedge i_clk_sys);
    end
    if (dbusy !== 1'b0) begin
      hang("device");
    end
  endtask
  task automatic write_latch_set_cmd;
    send(1, 8'h06);
  endtask
  task automatic status_write_cmd(input logic [7:0] v);
    write_latch_set_cmd();
    send(2, 8'h01, v);
    settle();
  endtask
  task automatic chk_sr(input logic [7:0] e);
    send(2, 8'h05);
    `CHK("status", e, rx[1])
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    `CHK("o_status", 8'hF0, dstat)
    chk_sr(8'hF0);
  endtask
  task automatic t_latch;
    write_latch_set_cmd();
    chk_sr(8'hF2);
    send(1, 8'hFF);
    chk_sr(8'hF2);
    send(1, 8'h0C);
    chk_sr(8'hF2);
    send(1, 8'h04);
    chk_sr(8'hF0);
    send(2, 8'h06);
    chk_sr(8'hF0);
  endtask
  task automatic t_write;
    write_latch_set_cmd();
    send(5, 8'h0A, 8'hFE, 8'hA1, 8'hB2, 8'hC3);
    chk_sr(8'hF3);
    settle();
    `CHK("busy", 1'b1, seen)
    chk_sr(8'hF0);
    send(4, 8'h0B, 8'hFE);
    `CHK("rd0", 8'hA1, rx[2])
    `CHK("rd1", 8'hB2, rx[3])
    send(3, 8'h0B, 8'hF0);
    `CHK("wrap", 8'hC3, rx[2])
  endtask
  task automatic t_guard;
    status_write_cmd(8'h04);
    chk_sr(8'hF4);
    write_latch_set_cmd();
    send(3, 8'h0A, 8'hF0, 8'h55);
    settle();
    `CHK("busy", 1'b0, seen)
    status_write_cmd(8'hAB);
    chk_sr(8'hF8);
    status_write_cmd(8'h50);
    chk_sr(8'hF0);
  endtask
  task automatic t_wp;
    @(negedge i_clk_sys);
    guard_n = 1'b0;
    write_latch_set_cmd();
    send(3, 8'h0A, 8'hFE, 8'h99);
    settle();
    `CHK("busy", 1'b0, seen)
    @(negedge i_clk_sys);
    guard_n = 1'b1;
    write_latch_set_cmd();
    // guard pulses low during the last data byte and is high again before that byte ends
    fork
      send(4, 8'h0A, 8'hFE, 8'h99, 8'h98);
      begin
        repeat (400) @(negedge i_clk_sys);
        guard_n = 1'b0;
        repeat (20) @(negedge i_clk_sys);
        guard_n = 1'b1;
      end
    join
    settle();
    `CHK("busy", 1'b0, seen)
    send(4, 8'h0B, 8'hFE);
    `CHK("kept", 8'hA1, rx[2])
    `CHK("kept1", 8'hB2, rx[3])
  endtask
  task automatic t_idpage;
    status_write_cmd(8'h10);
    chk_sr(8'hB0);
    write_latch_set_cmd();
    send(3, 8'h02, 8'h33, 8'h77);
    settle();
    `CHK("busy", 1'b1, seen)
    chk_sr(8'hF0);
    status_write_cmd(8'h10);
    send(3, 8'h03, 8'hF3);
    `CHK("idpage", 8'h77, rx[2])
    status_write_cmd(8'h1C);
    write_latch_set_cmd();
    send(3, 8'h02, 8'h33, 8'h88);
    settle();
    `CHK("busy", 1'b0, seen)
    status_write_cmd(8'h4C);
    status_write_cmd(8'h50);
    chk_sr(8'hE0);
    status_write_cmd(8'h10);
    write_latch_set_cmd();
    send(3, 8'h02, 8'h34, 8'h88);
    settle();
    `CHK("busy", 1'b0, seen)
  endtask
  initial begin
    foreach (tx[k]) begin
      tx[k] = 8'h00;
    end
    repeat (4) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_nrst = 1'b1;
    t_reset();
    t_latch();
    t_write();
    t_guard();
    t_wp();
    t_idpage();
    stop_test();
  end
endmodule // tb_spi_eeprom_command_write_control
`default_nettype wire
